// ### hw/dram_store.sv
// Internal DRAM model store reached by an external master during hold
// Assumes synchronous requests; read data come out of a register
`timescale 1ns/1ps
module dram_store
  import ext_bus_pkg::*;
#(
  parameter int unsigned DEPTH_W = 10
)
(
  input  wire logic  clk_sys_i,
  input  wire logic  sys_rst_i,
  input  wire logic  clk_en_i,
  dram_port_if.slave port
);
  import ext_bus_pkg::*;

  logic [DATA_W-1:0]  mem [2**DEPTH_W];
  logic [DATA_W-1:0]  rdata_ff;
  logic               ack_ff;
  wire  [DEPTH_W-1:0] idx = port.addr[DEPTH_W-1:0];

  assign port.rdata = rdata_ff;
  assign port.ack   = ack_ff;

  // Byte lanes: bit 1 is the high (most significant) byte
  always_ff @(posedge clk_sys_i)
  begin
    if (clk_en_i && port.req && port.wr && port.be[1])
      mem[idx][15:8] <= port.wdata[15:8];
    if (clk_en_i && port.req && port.wr && port.be[0])
      mem[idx][7:0] <= port.wdata[7:0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      rdata_ff <= '0;
      ack_ff   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      ack_ff <= port.req & ~ack_ff;
      if (port.req)
        rdata_ff <= mem[idx];
    end
  end
endmodule

// ### hw/ext_system_bus_hold_port.sv
// External 16-bit system bus port with hold and slave DRAM access
// Assumes all pins synchronous to clk_sys_i; a pad ring resolves enables
//
// Contract
// - space_select low for user space, high for I/O space cycles.
// - High strobe qualifies D0-D7 (msb), low strobe D8-D15 (lsb).
// - Every read cycle drives both byte strobes low.
// - Write cycle drives low only the strobes of written bytes.
// - Cycle-start strobe pulses low at start of each external cycle.
// - Burst pulses cycle-start for every transfer cycle.
// - On-chip accesses produce no cycle-start strobe.
// - Status low for fetch, high for operand cycles.
// - Device drives direction own cycles; external master drives in hold.
// - Word access is two cycles, upper half first, address bit low then high.
// - Fetches use up to 8 cycles in 128-bit block; 8 in cache mode.
// - Burst indicator low throughout a multi-cycle transfer.
// - 128-bit transfers start anywhere aligned, wrap inside the block.
// - Wait states inserted until slave asserts transfer_done.
// - Device drives transfer_done to finish hold DRAM cycles.
// - bus_hold_request low puts the device in hold.
// - bus_hold_grant asserted once hold is entered.
// - Chip select low in hold accesses DRAM at pin address.
// - transfer_done is output only while chip select is driven in.
// - Hold floats space, strobes, start, status, direction, burst, done.
`timescale 1ns/1ps
module ext_system_bus_hold_port
  import ext_bus_pkg::*;
#(
  parameter int unsigned DEPTH_W = 10
)
(
  input  wire logic                          clk_sys_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          clk_en_i,
  // Core request side
  input  wire logic                          req_valid_i,
  output wire logic                          req_ready_o,
  input  wire logic [ext_bus_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic                          req_space_i,
  input  wire logic                          req_fetch_i,
  input  wire logic                          req_write_i,
  input  wire logic                          req_word_i,
  input  wire logic [2:0]                    req_fetch_beats_i,
  input  wire logic                          cache_mode_i,
  input  wire logic [1:0]                    req_be_i,
  input  wire logic [31:0]                   req_wdata_i,
  input  wire logic                          req_internal_i,
  output logic                               rsp_valid_o,
  output logic [ext_bus_pkg::DATA_W-1:0]     rsp_data_o,
  // Address pins (bit 0 is the halfword address bit)
  input  wire logic [ext_bus_pkg::ADDR_W-1:0] addr_pin_i,
  output logic [ext_bus_pkg::ADDR_W-1:0]     addr_pin_o,
  output wire logic                          addr_pin_oe_o,
  // Data pins; [15:8] is D0-D7
  input  wire logic [ext_bus_pkg::DATA_W-1:0] data_pin_i,
  output logic [ext_bus_pkg::DATA_W-1:0]     data_pin_o,
  output wire logic                          data_pin_oe_o,
  output logic                               space_select_o,
  input  wire logic                          high_byte_strobe_n_i,
  output logic                               high_byte_strobe_n_o,
  input  wire logic                          low_byte_strobe_n_i,
  output logic                               low_byte_strobe_n_o,
  output wire logic                          strobe_oe_o,
  output wire logic                          cycle_start_strobe_n_o,
  output logic                               fetch_operand_status_o,
  input  wire logic                          rd_wr_n_i,
  output logic                               rd_wr_n_o,
  output wire logic                          ctrl_oe_o,
  output wire logic                          burst_n_o,
  input  wire logic                          transfer_done_n_i,
  output wire logic                          transfer_done_n_o,
  output wire logic                          transfer_done_oe_o,
  input  wire logic                          bus_hold_request_n_i,
  output wire logic                          bus_hold_grant_n_o,
  input  wire logic                          chip_select_n_i
);
  import ext_bus_pkg::*;

  bus_state_t              state_ff;
  bus_state_t              nxt_state;
  logic [BEAT_W-1:0]       beats_left_ff;
  logic [BEAT_W-1:0]       beat_ptr_ff;
  logic [DATA_W-1:0]       wlow_ff;
  logic                    word_ff;
  logic                    hold_ff;
  logic                    dram_busy_ff;
  logic                    burst_ff;
  logic [DATA_W-1:0]       drive_data_ff;

  dram_port_if dport ();

  dram_store #(.DEPTH_W(DEPTH_W)) u_store
  (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .port      (dport)
  );

  wire in_idle    = (state_ff == ST_IDLE);
  wire in_start   = (state_ff == ST_START);
  wire in_wait    = (state_ff == ST_WAIT);
  wire in_hold    = (state_ff == ST_HOLD) || (state_ff == ST_SLAVE);
  wire hold_req   = ~bus_hold_request_n_i;
  wire done_in    = ~transfer_done_n_i;
  wire cs_active  = in_hold && ~chip_select_n_i;
  wire last_beat  = (beats_left_ff == '0);
  wire beat_end   = in_wait && done_in;
  wire take_req   = in_idle && req_valid_i && ~hold_req;
  wire take_ext   = take_req && ~req_internal_i;
  wire fetch_len  = req_fetch_i && !req_write_i;
  wire [2:0] fetch_beats = cache_mode_i ? BEATS_LINE : req_fetch_beats_i;
  wire [2:0] first_left  = fetch_len ? fetch_beats
                         : (req_word_i ? BEATS_WORD : 3'h0);

  // Internal targets answer at once and never touch the pins
  assign req_ready_o = take_req && req_internal_i
                     || (beat_end && last_beat);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (hold_req)
          nxt_state = ST_HOLD;
        else if (take_ext)
          nxt_state = ST_START;
      ST_START:
        nxt_state = ST_WAIT;
      ST_WAIT:
        if (done_in)
          nxt_state = last_beat ? ST_IDLE : ST_START;
      ST_HOLD:
        if (!hold_req)
          nxt_state = ST_IDLE;
        else if (!chip_select_n_i)
          nxt_state = ST_SLAVE;
      ST_SLAVE:
        if (chip_select_n_i)
          nxt_state = ST_HOLD;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      state_ff <= ST_IDLE;
    else if (clk_en_i)
      state_ff <= nxt_state;
  end

  // Beat sequencing for word pairs and wrapped line fetches
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      beats_left_ff <= '0;
      beat_ptr_ff   <= '0;
      word_ff       <= 1'b0;
      burst_ff      <= 1'b0;
      wlow_ff       <= '0;
      addr_pin_o    <= '0;
    end
    else if (clk_en_i)
    begin
      if (take_ext)
      begin
        beats_left_ff <= first_left;
        beat_ptr_ff   <= req_addr_i[BEAT_W-1:0];
        word_ff       <= req_word_i && !fetch_len;
        // Any access of more than one beat keeps burst low to its end
        burst_ff      <= (first_left != 3'h0);
        wlow_ff       <= req_wdata_i[15:0];
        // Word accesses start on the upper half
        addr_pin_o    <= (req_word_i && !fetch_len)
                       ? {req_addr_i[ADDR_W-1:1], 1'b0}
                       : req_addr_i;
      end
      else if (beat_end && !last_beat)
      begin
        beats_left_ff <= beats_left_ff - 3'h1;
        beat_ptr_ff   <= beat_ptr_ff + 3'h1;
        // Wrap inside the 128-bit block
        addr_pin_o[BEAT_W-1:0] <= beat_ptr_ff + 3'h1;
      end
    end
  end

  // Cycle qualifiers latched for the whole access
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      space_select_o         <= SPACE_USER;
      fetch_operand_status_o <= STAT_OPERAND;
      rd_wr_n_o              <= DIR_READ;
      high_byte_strobe_n_o   <= 1'b1;
      low_byte_strobe_n_o    <= 1'b1;
      drive_data_ff          <= '0;
      rsp_valid_o            <= 1'b0;
      rsp_data_o             <= '0;
    end
    else if (clk_en_i)
    begin
      rsp_valid_o <= beat_end && (rd_wr_n_o == DIR_READ);
      if (beat_end)
        rsp_data_o <= data_pin_i;
      if (take_ext)
      begin
        space_select_o         <= req_space_i;
        fetch_operand_status_o <= fetch_len ? STAT_FETCH
                                            : STAT_OPERAND;
        rd_wr_n_o              <= req_write_i ? DIR_WRITE : DIR_READ;
        // Reads drive both strobes; writes only the written lanes
        high_byte_strobe_n_o   <= req_write_i ? ~req_be_i[1]
                                              : 1'b0;
        low_byte_strobe_n_o    <= req_write_i ? ~req_be_i[0]
                                              : 1'b0;
        drive_data_ff          <= req_word_i ? req_wdata_i[31:16]
                                             : req_wdata_i[15:0];
      end
      else if (beat_end && word_ff)
        drive_data_ff <= wlow_ff;
    end
  end

  // One-cycle start strobe per beat, burst low for multi-beat accesses
  assign cycle_start_strobe_n_o = in_hold ? 1'b1 : ~in_start;
  assign burst_n_o = ~((in_start || in_wait) && burst_ff);

  // Grant only after the running access has finished
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      hold_ff <= 1'b0;
    else if (clk_en_i)
      hold_ff <= in_hold;
  end
  assign bus_hold_grant_n_o = ~(hold_ff && in_hold);

  // Pin directions: float everything in hold except slave read data and done
  assign addr_pin_oe_o  = ~in_hold;
  assign ctrl_oe_o      = ~in_hold;
  assign strobe_oe_o    = ~in_hold;
  assign data_pin_oe_o  = ~in_hold && (in_start || in_wait)
                        && (rd_wr_n_o == DIR_WRITE)
                        || (state_ff == ST_SLAVE) && (rd_wr_n_i == DIR_READ)
                           && dport.ack;
  // Slave reads put the store's registered data on the pins
  assign data_pin_o     = (state_ff == ST_SLAVE) ? dport.rdata
                                                 : drive_data_ff;

  // Slave access to the internal store during hold
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      dram_busy_ff <= 1'b0;
    else if (clk_en_i)
      dram_busy_ff <= cs_active && (dram_busy_ff || dport.ack);
  end
  // One store access per chip select assertion
  assign dport.req   = (state_ff == ST_SLAVE) && !chip_select_n_i
                     && !dram_busy_ff && !dport.ack;
  assign dport.wr    = (rd_wr_n_i == DIR_WRITE);
  assign dport.addr  = addr_pin_i[DRAM_AW-1:0];
  assign dport.be    = {~high_byte_strobe_n_i, ~low_byte_strobe_n_i};
  assign dport.wdata = data_pin_i;
  assign transfer_done_oe_o = cs_active;
  assign transfer_done_n_o  = ~(cs_active && dport.ack);

  a_start_single: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    !cycle_start_strobe_n_o && clk_en_i |=> cycle_start_strobe_n_o)
    else $error("start strobe longer than one cycle");
  a_start_pulse: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !cycle_start_strobe_n_o |-> !ctrl_oe_o == 1'b0)
    else $error("start strobe while floating");
  a_float_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !bus_hold_grant_n_o |-> !ctrl_oe_o && !addr_pin_oe_o)
    else $error("outputs driven during hold");
  a_read_strobes: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    in_wait && rd_wr_n_o == DIR_READ
    |-> !high_byte_strobe_n_o && !low_byte_strobe_n_o)
    else $error("read cycle without both strobes");
  a_done_dir: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    transfer_done_oe_o |-> !chip_select_n_i && in_hold)
    else $error("done pin driven without chip select");
  a_grant_idle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(bus_hold_grant_n_o) |-> $past(in_hold) && !in_wait)
    else $error("grant before cycle finished");
  a_wait_done: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    in_wait && transfer_done_n_i && clk_en_i |=> in_wait)
    else $error("cycle ended without done");
  a_hold_enter: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    in_idle && hold_req && clk_en_i |=> in_hold ##1 !bus_hold_grant_n_o
    || !clk_en_i)
    else $error("hold not entered");
  a_word_order: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    take_ext && req_word_i && !fetch_len && clk_en_i
    |=> addr_pin_o[0] == 1'b0)
    else $error("word access not upper half first");
  a_burst_cont: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    beat_end && !last_beat && clk_en_i |=> !burst_n_o ##1 !burst_n_o)
    else $error("burst indicator rose inside a transfer");
  a_internal_quiet: assert property (@(posedge clk_sys_i)
    disable iff (sys_rst_i)
    take_req && req_internal_i |=> cycle_start_strobe_n_o)
    else $error("start strobe on an on-chip access");
endmodule

// ### pkg/dram_port_if.sv
// Interface: internal DRAM access port between bus port and DRAM store
// Assumes one clock domain; the store answers one cycle after a request
`timescale 1ns/1ps
interface dram_port_if
  import ext_bus_pkg::*;
();
  logic                req;
  logic                wr;
  logic [DRAM_AW-1:0]  addr;
  logic [1:0]          be;
  logic [DATA_W-1:0]   wdata;
  logic [DATA_W-1:0]   rdata;
  logic                ack;

  modport master (output req, output wr, output addr, output be,
                  output wdata, input rdata, input ack);
  modport slave  (input req, input wr, input addr, input be,
                  input wdata, output rdata, output ack);
endinterface

// ### pkg/ext_bus_pkg.sv
// Package: constants and types shared by the external bus hold port
// Assumes a single 200 MHz system clock domain
package ext_bus_pkg;
  localparam int unsigned ADDR_W       = 23;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned DRAM_AW      = 20;
  localparam int unsigned BURST_MAX    = 8;
  localparam int unsigned BEAT_W       = 3;
  localparam logic [2:0]  BEATS_WORD   = 3'h1;
  localparam logic [2:0]  BEATS_LINE   = 3'h7;
  localparam logic        SPACE_USER   = 1'b0;
  localparam logic        SPACE_IO     = 1'b1;
  localparam logic        STAT_FETCH   = 1'b0;
  localparam logic        STAT_OPERAND = 1'b1;
  localparam logic        DIR_READ     = 1'b1;
  localparam logic        DIR_WRITE    = 1'b0;

  typedef enum logic [4:0]
  {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_WAIT  = 5'h04,
    ST_HOLD  = 5'h08,
    ST_SLAVE = 5'h10
  } bus_state_t;
endpackage

// ### verification/ext_slave_model.sv
// Partner model: external slave answering device-driven bus cycles
// Assumes transfer_done carries a pull-up; data lines float undefined
`timescale 1ns/1ps
module ext_slave_model
(
  input  wire logic                          clk_i,
  input  wire logic                          start_n_i,
  input  wire logic [ext_bus_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [5:0]                    info_i,
  input  wire logic [ext_bus_pkg::DATA_W-1:0] data_i,
  input  wire logic [3:0]                    lat_i,
  output logic [ext_bus_pkg::DATA_W-1:0]     data_o,
  output logic                               done_n_o
);
  import ext_bus_pkg::*;
  logic [ADDR_W-1:0] addr_q[$];
  logic [5:0]        info_q[$];
  logic [DATA_W-1:0] wd_q[$];
  logic [ADDR_W-1:0] cur_a;
  logic [5:0]        cur_i;

  initial
  begin
    done_n_o = 1'b1;
    data_o   = 16'h0000;
    forever
    begin
      @(posedge clk_i);
      if (start_n_i === 1'b0)
      begin
        cur_a = addr_i;
        cur_i = info_i;
        addr_q.push_back(cur_a);
        info_q.push_back(cur_i);
        repeat (lat_i) @(posedge clk_i);
        #1;
        done_n_o = 1'b0;
        data_o   = {cur_a[7:0], ~cur_a[7:0]};
        @(posedge clk_i);
        if (cur_i[2] === 1'b0)
          wd_q.push_back(data_i);
        #1;
        done_n_o = 1'b1;
        // Released lines must not keep the last value
        data_o   = ~data_o;
      end
    end
  end
endmodule

// ### verification/tb.sv
// Testbench: bus cycles, bursts, internal access and hold slave access
// Assumes the slave model on the pins; the bench plays the hold master
`timescale 1ns/1ps
module tb;
  import ext_bus_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              valid, space, fetch, write, word, cache, internal;
  logic [2:0]        beats;
  logic [1:0]        be;
  logic [31:0]       wdata;
  logic [ADDR_W-1:0] addr, x_addr;
  logic              hold_n, cs_n, x_rw, x_hbs, x_lbs;
  logic [15:0]       x_data, r;
  logic [3:0]        lat;
  logic [15:0]       rsp_q[$];
  int                num_errors = 0;
  int                n_compared = 0;
  wire               ready, rsp_valid, a_oe, d_oe, space_o, hbs_o, lbs_o;
  wire               s_oe, start_n, status_o, rw_o, c_oe, burst_n;
  wire               dn_o, dn_oe, grant_n, p_done;
  wire [15:0]        rsp_data, d_o, p_data;
  wire [ADDR_W-1:0]  a_o;
  wire [ADDR_W-1:0]  a_bus   = a_oe ? a_o : x_addr;
  wire [15:0]        d_bus   = d_oe ? d_o : (c_oe ? p_data : x_data);
  wire               hbs_bus = s_oe ? hbs_o : x_hbs;
  wire               lbs_bus = s_oe ? lbs_o : x_lbs;
  wire               rw_bus  = c_oe ? rw_o : x_rw;
  wire               dn_bus  = dn_oe ? dn_o : p_done;
  wire               st_bus  = c_oe ? start_n : 1'b1;
  wire [5:0]         info = {space_o, hbs_bus, lbs_bus, rw_bus, status_o,
                             burst_n};

  always #2.5 clk = ~clk;

  ext_system_bus_hold_port i_ext_system_bus_hold_port (
    .clk_sys_i(clk), .sys_rst_i(rst), .clk_en_i(1'b1),
    .req_valid_i(valid), .req_ready_o(ready), .req_addr_i(addr),
    .req_space_i(space), .req_fetch_i(fetch), .req_write_i(write),
    .req_word_i(word), .req_fetch_beats_i(beats), .cache_mode_i(cache),
    .req_be_i(be), .req_wdata_i(wdata), .req_internal_i(internal),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .addr_pin_i(a_bus), .addr_pin_o(a_o), .addr_pin_oe_o(a_oe),
    .data_pin_i(d_bus), .data_pin_o(d_o), .data_pin_oe_o(d_oe),
    .space_select_o(space_o), .high_byte_strobe_n_i(hbs_bus),
    .high_byte_strobe_n_o(hbs_o), .low_byte_strobe_n_i(lbs_bus),
    .low_byte_strobe_n_o(lbs_o), .strobe_oe_o(s_oe),
    .cycle_start_strobe_n_o(start_n), .fetch_operand_status_o(status_o),
    .rd_wr_n_i(rw_bus), .rd_wr_n_o(rw_o), .ctrl_oe_o(c_oe),
    .burst_n_o(burst_n), .transfer_done_n_i(dn_bus),
    .transfer_done_n_o(dn_o), .transfer_done_oe_o(dn_oe),
    .bus_hold_request_n_i(hold_n), .bus_hold_grant_n_o(grant_n),
    .chip_select_n_i(cs_n));

  ext_slave_model i_partner (
    .clk_i(clk), .start_n_i(st_bus), .addr_i(a_bus), .info_i(info),
    .data_i(d_bus), .lat_i(lat), .data_o(p_data), .done_n_o(p_done));

  always @(posedge clk)
    if (rsp_valid === 1'b1)
      rsp_q.push_back(rsp_data);

  function automatic logic [15:0] rd_val(input logic [ADDR_W-1:0] a);
    return {a[7:0], ~a[7:0]};
  endfunction

  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait at negedge for a settled condition
  task automatic wait_for(input int sel);
    int i;
    for (i = 0; i < 300; i++)
    begin
      @(negedge clk);
      if (sel == 0 && ready === 1'b1) break;
      if (sel == 1 && grant_n === 1'b0) break;
      if (sel == 2 && dn_oe === 1'b1 && dn_o === 1'b0) break;
      if (sel == 3 && grant_n === 1'b1) break;
    end
    if (i == 300)
    begin
      num_errors++;
      finish_test();
    end
  endtask

  // Kind bits: space, fetch, write, word, internal
  task automatic do_req(input logic [ADDR_W-1:0] a, input logic [4:0] k,
                        input logic [2:0] nb, input logic [1:0] lanes,
                        input logic [31:0] wd);
    {space, fetch, write, word, internal} = k;
    addr = a;
    beats = nb;
    be = lanes;
    wdata = wd;
    valid = 1'b1;
    wait_for(0);
    @(posedge clk);
    #1;
    valid = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic check_beats(input logic [ADDR_W-1:0] a0, input int n,
                             input logic [5:0] inf, input bit rd);
    logic [ADDR_W-1:0] a;
    check(32'(i_partner.addr_q.size()), 32'(n));
    for (int i = 0; i < n; i++)
    begin
      a = {a0[ADDR_W-1:3], a0[2:0] + 3'(i)};
      check(32'(i_partner.addr_q.pop_front()), 32'(a));
      check(32'(i_partner.info_q.pop_front()), 32'(inf));
      if (rd)
        check(32'(rsp_q.pop_front()), 32'(rd_val(a)));
    end
  endtask

  task automatic ext_acc(input logic rd, input logic [1:0] lanes,
                         input logic [15:0] wd);
    x_addr = 23'h000005;
    x_rw = rd;
    {x_hbs, x_lbs} = ~lanes;
    x_data = wd;
    cs_n = 1'b0;
    wait_for(2);
    r = d_bus;
    @(posedge clk);
    #1;
    cs_n = 1'b1;
    {x_hbs, x_lbs} = 2'b11;
    x_data = ~wd;
    @(posedge clk);
    #1;
  endtask

  task automatic t_read;
    lat = 4'h3;
    do_req(23'h000100, 5'b00000, 3'h0, 2'b11, 32'h0);
    check_beats(23'h000100, 1, 6'b000111, 1'b1);
  endtask

  task automatic t_write;
    lat = 4'h0;
    do_req(23'h000200, 5'b10110, 3'h0, 2'b10, 32'hcafef00d);
    check_beats(23'h000200, 2, 6'b101010, 1'b0);
    check(32'(i_partner.wd_q.pop_front() >> 8), 32'h00ca);
    check(32'(i_partner.wd_q.pop_front() >> 8), 32'h00f0);
  endtask

  task automatic t_fetch;
    lat = 4'h1;
    cache = 1'b1;
    do_req(23'h000305, 5'b01000, 3'h0, 2'b11, 32'h0);
    cache = 1'b0;
    check_beats(23'h000305, 8, 6'b000100, 1'b1);
  endtask

  task automatic t_internal;
    do_req(23'h000040, 5'b00001, 3'h0, 2'b11, 32'h0);
    check(32'(i_partner.addr_q.size()), 32'h0);
    rsp_q.delete();
  endtask

  task automatic t_hold;
    fork
      do_req(23'h000016, 5'b01000, 3'h3, 2'b11, 32'h0);
      begin
        repeat (2) @(posedge clk);
        #1;
        hold_n = 1'b0;
        wait_for(1);
        check(32'(i_partner.addr_q.size()), 32'h4);
        @(posedge clk);
        #1;
      end
    join
    check_beats(23'h000016, 4, 6'b000100, 1'b1);
    check({a_oe, s_oe, c_oe, dn_oe}, 32'h0);
    ext_acc(1'b0, 2'b11, 16'hbeef);
    ext_acc(1'b0, 2'b10, 16'h12aa);
    ext_acc(1'b1, 2'b11, 16'h0000);
    check(32'(r), 32'h12ef);
    hold_n = 1'b1;
    wait_for(3);
    @(posedge clk);
    #1;
    check({a_oe, c_oe}, 32'h3);
  endtask

  initial
  begin
    {valid, space, fetch, write, word, cache, internal} = 7'h00;
    {beats, be, wdata, addr, x_addr, x_data, lat} = '0;
    {hold_n, cs_n, x_rw, x_hbs, x_lbs} = 5'h1f;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    check(32'(grant_n), 32'h1);
    t_read();
    t_write();
    t_fetch();
    t_internal();
    t_hold();
    finish_test();
  end

  initial
  begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule
